// ---- common/hbs_pkg.sv ----
// package with stage, strap and timing constants of the hub boot sequencer
package hbs_pkg;
	// boot stages
	typedef enum logic [3:0] {
		HBS_STANDBY,
		HBS_SPI_INIT,
		HBS_SPI_PROBE,
		HBS_SPI_EXEC,
		HBS_CFG_READ,
		HBS_STRAP_CHECK,
		HBS_SOC_CFG,
		HBS_MERGE,
		HBS_IDLE,
		HBS_SUSPEND,
		HBS_CHARGER_DETECT,
		HBS_CONNECT
	} hbs_stage_t;

	// six-level strap codes
	localparam logic [2:0] HBS_STRAP_PD200K = 3'h0;
	localparam logic [2:0] HBS_STRAP_PU200K = 3'h1;
	localparam logic [2:0] HBS_STRAP_PD10K = 3'h2;
	localparam logic [2:0] HBS_STRAP_PU10K = 3'h3;
	localparam logic [2:0] HBS_STRAP_PD10R = 3'h4;
	localparam logic [2:0] HBS_STRAP_PU10R = 3'h5;

	// charging port enable masks, port 1 in bit 0
	localparam logic [5:0] HBS_CHG_NONE = 6'h00;
	localparam logic [5:0] HBS_CHG_P1 = 6'h01;
	localparam logic [5:0] HBS_CHG_P12 = 6'h03;
	localparam logic [5:0] HBS_CHG_P123 = 6'h07;
	localparam logic [5:0] HBS_CHG_P1234 = 6'h0F;
	localparam logic [5:0] HBS_CHG_ALL = 6'h3F;

	// rom signature "2DFU" at 0xFFFA, execution at 0x0000
	localparam logic [31:0] HBS_SIGNATURE = 32'h32444655;
	localparam logic [23:0] HBS_SIG_ADDR = 24'h00FFFA;
	localparam logic [23:0] HBS_EXEC_ADDR = 24'h000000;
	// register written by the soc to finish configuration
	localparam logic [7:0] HBS_SOC_DONE_REG = 8'hFF;

	// pll lock wait and merge time, in ns
	localparam int HBS_PLL_LOCK_NS = 1000;
	localparam int HBS_MERGE_NS = 200;
	localparam int HBS_CLK_NS = 10;
	localparam int HBS_PLL_LOCK_CYC = (HBS_PLL_LOCK_NS + HBS_CLK_NS - 1) / HBS_CLK_NS;
	localparam int HBS_MERGE_CYC = (HBS_MERGE_NS + HBS_CLK_NS - 1) / HBS_CLK_NS;
	localparam logic [7:0] HBS_RESET_Q = 8'h00;
	localparam logic [7:0] HBS_GPIO_RESET = 8'h00;
endpackage

// ---- core/hbs_strap_decode.sv ----
// six-level strap resolver: direction and strength into a held code
module hbs_strap_decode
	import hbs_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	input wire logic capture_in,
	input wire logic pull_up_in,
	input wire logic strong_in,
	input wire logic very_strong_in,
	output logic [2:0] code_out
);
	logic [2:0] code_d;

	// strength picks the pair, direction the member
	always_comb
	begin
		if (very_strong_in)
			code_d = pull_up_in ? HBS_STRAP_PU10R : HBS_STRAP_PD10R;
		else if (strong_in)
			code_d = pull_up_in ? HBS_STRAP_PU10K : HBS_STRAP_PD10K;
		else
			code_d = pull_up_in ? HBS_STRAP_PU200K : HBS_STRAP_PD200K;
	end

	// held from the capture pulse until the next reset
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			code_out <= HBS_STRAP_PD200K;
		else if (capture_in)
			code_out <= code_d;
	end

	held_code_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!capture_in |=> code_out == $past(code_out)) else $error("strap code moved");
endmodule

// ---- core/hbs_boot_sequencer.sv ----
// boot and operating-mode sequencer with strap capture and gpio control
module hbs_boot_sequencer
	import hbs_pkg::*;
#(
	parameter int GPIO_N = 8
)
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// charge port strap sense
	input wire logic chg_pull_up_in,
	input wire logic chg_strong_in,
	input wire logic chg_very_strong_in,
	// interface mode strap sense
	input wire logic cfg_pull_up_in,
	input wire logic cfg_strong_in,
	input wire logic cfg_very_strong_in,
	input wire logic spi_strap_in,
	// pull-up sense on management pins
	input wire logic mgmt_data_pin_pu_in,
	input wire logic mgmt_clock_pin_pu_in,
	// spi probe engine
	input wire logic pll_locked_in,
	input wire logic rom_done_in,
	input wire logic [31:0] rom_data_in,
	input wire logic rom_dual_in,
	input wire logic rom_mode3_in,
	// slave register writes from soc
	input wire logic slv_wr_in,
	input wire logic [7:0] slv_addr_in,
	input wire logic [7:0] slv_data_in,
	// host feature controller gpio writes
	input wire logic host_wr_in,
	input wire logic [7:0] host_addr_in,
	input wire logic [7:0] host_data_in,
	input wire logic otp_override_in,
	input wire logic vbus_in,
	input wire logic [GPIO_N-1:0] gpio_pin_in,
	output logic [3:0] stage_out,
	output logic pll_run_out,
	output logic port_oe_out,
	output logic rom_rd_out,
	output logic [23:0] rom_addr_out,
	output logic rom_dual_out,
	output logic rom_mode3_out,
	output logic exec_external_out,
	output logic mgmt_slave_out,
	output logic [5:0] charge_en_out,
	output logic [2:0] slave_config_setting_out,
	output logic config_locked_out,
	output logic charger_detect_stage_out,
	output logic hub_connect_out,
	output logic [GPIO_N-1:0] gpio_out,
	output logic [GPIO_N-1:0] gpio_oe_out,
	output logic [GPIO_N-1:0] gpio_pu_en_out,
	output logic [GPIO_N-1:0] gpio_pd_en_out,
	output logic [GPIO_N-1:0] gpio_in_q_out
);
	hbs_stage_t stage_q, stage_d;
	logic [15:0] tmr_q;
	logic capture_q;
	logic released_q;
	logic [2:0] chg_code;
	logic [2:0] cfg_code;
	logic spi_strap_q;
	logic soc_done;
	logic [5:0] chg_mask;
	logic [GPIO_N-1:0] dir_q, lvl_q, pull_sel_q, pull_en_q;

	// one-cycle capture pulse just after reset release
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			released_q <= 1'b0;
			capture_q <= 1'b0;
		end
		else
		begin
			released_q <= 1'b1;
			capture_q <= !released_q;
		end
	end

	// straps are resolved by the leaf and held until reset
	hbs_strap_decode u_chg_strap (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.capture_in(capture_q),
		.pull_up_in(chg_pull_up_in),
		.strong_in(chg_strong_in),
		.very_strong_in(chg_very_strong_in),
		.code_out(chg_code)
	);

	hbs_strap_decode u_cfg_strap (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.capture_in(capture_q),
		.pull_up_in(cfg_pull_up_in),
		.strong_in(cfg_strong_in),
		.very_strong_in(cfg_very_strong_in),
		.code_out(cfg_code)
	);

	// spi strap is a plain level, caught by a clocked process
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			spi_strap_q <= 1'b0;
		else if (capture_q)
			spi_strap_q <= spi_strap_in;
	end

	// charge strap to port mask
	always_comb
	begin
		case (chg_code)
			HBS_STRAP_PD200K: chg_mask = HBS_CHG_NONE;
			HBS_STRAP_PU200K: chg_mask = HBS_CHG_P1;
			HBS_STRAP_PD10K: chg_mask = HBS_CHG_P12;
			HBS_STRAP_PU10K: chg_mask = HBS_CHG_P123;
			HBS_STRAP_PD10R: chg_mask = HBS_CHG_P1234;
			default: chg_mask = HBS_CHG_ALL;
		endcase
	end

	assign soc_done = slv_wr_in && slv_addr_in == HBS_SOC_DONE_REG;

	// stage walk; async reset is the standby entry
	always_comb
	begin
		stage_d = stage_q;
		case (stage_q)
			HBS_STANDBY: stage_d = HBS_SPI_INIT;
			HBS_SPI_INIT:
				if (pll_locked_in && tmr_q >= 16'(HBS_PLL_LOCK_CYC) && !capture_q)
					stage_d = spi_strap_q ? HBS_SPI_PROBE : HBS_CFG_READ;
			HBS_SPI_PROBE:
				if (rom_done_in)
					stage_d = (rom_data_in == HBS_SIGNATURE) ? HBS_SPI_EXEC : HBS_CFG_READ;
			HBS_SPI_EXEC: stage_d = HBS_CFG_READ;
			HBS_CFG_READ: stage_d = HBS_STRAP_CHECK;
			HBS_STRAP_CHECK:
				if (cfg_code == HBS_STRAP_PU200K && mgmt_data_pin_pu_in && mgmt_clock_pin_pu_in)
					stage_d = HBS_SOC_CFG;
				else
					stage_d = HBS_MERGE;
			HBS_SOC_CFG:
				if (soc_done)
					stage_d = HBS_MERGE;
			HBS_MERGE:
				if (tmr_q >= 16'(HBS_MERGE_CYC))
					stage_d = HBS_IDLE;
			HBS_IDLE:
				if (vbus_in)
					stage_d = (chg_mask != HBS_CHG_NONE) ? HBS_CHARGER_DETECT : HBS_CONNECT;
				else
					stage_d = HBS_SUSPEND;
			HBS_SUSPEND:
				if (vbus_in)
					stage_d = (chg_mask != HBS_CHG_NONE) ? HBS_CHARGER_DETECT : HBS_CONNECT;
			HBS_CHARGER_DETECT: stage_d = HBS_CONNECT;
			HBS_CONNECT:
				if (!vbus_in)
					stage_d = HBS_IDLE;
			default: stage_d = HBS_STANDBY;
		endcase
	end

	// stage register returns to standby whenever reset is low
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			stage_q <= HBS_STANDBY;
		else
			stage_q <= stage_d;
	end

	// stage dwell counter, cleared on every stage change
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			tmr_q <= 16'h0000;
		else if (stage_d != stage_q)
			tmr_q <= 16'h0000;
		else if (tmr_q != 16'hFFFF)
			tmr_q <= tmr_q + 16'h0001;
	end

	// rom probe: signature address then execution address; single/dual, mode 0/3
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rom_rd_out <= 1'b0;
			rom_addr_out <= HBS_SIG_ADDR;
			rom_dual_out <= 1'b0;
			rom_mode3_out <= 1'b0;
			exec_external_out <= 1'b0;
		end
		else
		begin
			rom_rd_out <= stage_d == HBS_SPI_PROBE && !rom_done_in;
			rom_dual_out <= rom_dual_in;
			rom_mode3_out <= rom_mode3_in;
			if (stage_q == HBS_SPI_PROBE && stage_d == HBS_SPI_EXEC)
			begin
				exec_external_out <= 1'b1;
				rom_addr_out <= HBS_EXEC_ADDR;
			end
		end
	end

	// status and mode outputs; all cleared by reset so nothing survives standby
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			stage_out <= 4'h0;
			pll_run_out <= 1'b0;
			port_oe_out <= 1'b0;
			mgmt_slave_out <= 1'b0;
			charge_en_out <= HBS_CHG_NONE;
			slave_config_setting_out <= HBS_STRAP_PD200K;
			config_locked_out <= 1'b0;
			charger_detect_stage_out <= 1'b0;
			hub_connect_out <= 1'b0;
		end
		else
		begin
			stage_out <= stage_d;
			pll_run_out <= 1'b1;
			port_oe_out <= stage_d == HBS_CONNECT;
			mgmt_slave_out <= cfg_code == HBS_STRAP_PU200K;
			charge_en_out <= chg_mask;
			slave_config_setting_out <= cfg_code;
			config_locked_out <= stage_d == HBS_IDLE || stage_d == HBS_SUSPEND ||
				stage_d == HBS_CHARGER_DETECT || stage_d == HBS_CONNECT;
			charger_detect_stage_out <= stage_d == HBS_CHARGER_DETECT;
			hub_connect_out <= stage_d == HBS_CONNECT && vbus_in;
		end
	end

	// gpio config: host writes win over slave writes in the same cycle; reg 0..3 select field
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			dir_q <= GPIO_N'(HBS_GPIO_RESET);
			lvl_q <= GPIO_N'(HBS_GPIO_RESET);
			pull_sel_q <= GPIO_N'(HBS_GPIO_RESET);
			pull_en_q <= GPIO_N'(HBS_GPIO_RESET);
		end
		else if (config_locked_out && (host_wr_in || (slv_wr_in && !soc_done)))
		begin
			case (host_wr_in ? host_addr_in[1:0] : slv_addr_in[1:0])
				2'h0: dir_q <= GPIO_N'(host_wr_in ? host_data_in : slv_data_in);
				2'h1: lvl_q <= GPIO_N'(host_wr_in ? host_data_in : slv_data_in);
				2'h2: pull_sel_q <= GPIO_N'(host_wr_in ? host_data_in : slv_data_in);
				default: pull_en_q <= GPIO_N'(host_wr_in ? host_data_in : slv_data_in);
			endcase
		end
	end

	// pin drive; pulls only on inputs
	always_ff @(posedge mclk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			gpio_out <= '0;
			gpio_oe_out <= '0;
			gpio_pu_en_out <= '0;
			gpio_pd_en_out <= '0;
			gpio_in_q_out <= '0;
		end
		else
		begin
			gpio_out <= lvl_q;
			gpio_oe_out <= dir_q;
			gpio_pu_en_out <= ~dir_q & pull_en_q & pull_sel_q;
			gpio_pd_en_out <= ~dir_q & pull_en_q & ~pull_sel_q;
			gpio_in_q_out <= gpio_pin_in;
		end
	end

	soc_wait_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		stage_q == HBS_SOC_CFG && !soc_done |=> stage_q == HBS_SOC_CFG)
		else $error("soc stage left early");
	soc_enter_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		stage_q == HBS_STRAP_CHECK |=> stage_q == (cfg_code == HBS_STRAP_PU200K &&
		$past(mgmt_data_pin_pu_in) && $past(mgmt_clock_pin_pu_in) ? HBS_SOC_CFG : HBS_MERGE))
		else $error("wrong strap check branch");
	probe_skip_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		stage_q == HBS_SPI_INIT && !spi_strap_q |=> stage_q != HBS_SPI_PROBE)
		else $error("probe without spi strap");
	sig_match_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		stage_q == HBS_SPI_PROBE && rom_done_in && rom_data_in == HBS_SIGNATURE
		|=> stage_q == HBS_SPI_EXEC ##1 exec_external_out && rom_addr_out == HBS_EXEC_ADDR)
		else $error("signature match not honoured");
	connect_drop_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		stage_q == HBS_CONNECT && !vbus_in |=> stage_q == HBS_IDLE ##1 !hub_connect_out)
		else $error("connect kept without bus power");
	suspend_go_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		stage_q == HBS_IDLE && !vbus_in |=> stage_q == HBS_SUSPEND)
		else $error("no suspend without bus power");
	charge_map_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		chg_code == HBS_STRAP_PU10K |=> charge_en_out == HBS_CHG_P123)
		else $error("charge strap misdecoded");
	pull_input_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		##1 (gpio_oe_out & (gpio_pu_en_out | gpio_pd_en_out)) == '0)
		else $error("pull on an output gpio");
	// lock wait and merge dwell are minimums; leaving early would use half-built state
	pll_wait_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		stage_q == HBS_SPI_INIT && (!pll_locked_in || tmr_q < 16'(HBS_PLL_LOCK_CYC))
		|=> stage_q == HBS_SPI_INIT)
		else $error("lock wait cut short");
	merge_wait_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		stage_q == HBS_MERGE && tmr_q < 16'(HBS_MERGE_CYC)
		|=> stage_q == HBS_MERGE)
		else $error("merge cut short");
	// gpio settings stay put until the hub is configured
	gpio_refuse_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		!config_locked_out |=> dir_q == $past(dir_q) && pull_en_q == $past(pull_en_q))
		else $error("gpio written before configuration");
	host_win_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		config_locked_out && host_wr_in && slv_wr_in && host_addr_in[1:0] == 2'h0
		|=> dir_q == GPIO_N'($past(host_data_in)))
		else $error("slave write beat the host");
	connect_power_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
		hub_connect_out |-> $past(vbus_in))
		else $error("connect without bus power");
endmodule

// ---- testbench/hbs_far_model.sv ----
// far-side model: spi flash answering the probe and a configuring soc
module hbs_far_model
	import hbs_pkg::*;
(
	input wire logic mclk_in,
	input wire logic rom_rd_in,
	input wire logic [23:0] rom_addr_in,
	input wire logic sig_ok_in,
	input wire logic [2:0] lag_in,
	output logic rom_done_out,
	output logic [31:0] rom_data_out,
	output logic slv_wr_out,
	output logic [7:0] slv_addr_out,
	output logic [7:0] slv_data_out
);
	timeunit 1ns;
	timeprecision 1ns;

	// flash of 1 mbit at 60 mhz or more, so lag models only its access time
	initial
	begin
		rom_done_out = 1'b0;
		rom_data_out = 32'hA55A5AA5;
		slv_wr_out = 1'b0;
		slv_addr_out = 8'h5A;
		slv_data_out = 8'hA5;
		forever
		begin
			@(negedge mclk_in);
			if (rom_rd_in && !rom_done_out)
			begin
				repeat (lag_in) @(negedge mclk_in);
				rom_done_out = 1'b1;
				// signature only where it lives, never a stale word elsewhere
				rom_data_out = (sig_ok_in && rom_addr_in === HBS_SIG_ADDR) ? HBS_SIGNATURE
					: ~HBS_SIGNATURE;
			end
			else if (!rom_rd_in)
			begin
				rom_done_out = 1'b0;
				rom_data_out = ~rom_data_out;
			end
		end
	end

	// one-cycle slave write; released lines flip so no old value lingers
	task automatic soc_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk_in);
		slv_wr_out = 1'b1;
		slv_addr_out = a;
		slv_data_out = d;
		@(negedge mclk_in);
		slv_wr_out = 1'b0;
		slv_addr_out = ~a;
		slv_data_out = ~d;
	endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the hub boot sequencer
module tb_top
	import hbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk, rst_n, spi, lock, rom_done, dual, mode3, slv_wr, host_wr, vbus, sig_ok, rom_rd;
	logic ext, slave, locked, chg_det, hub_con, pll_run, port_oe, dual_o, mode3_o;
	logic [2:0] chg, cfg, cfg_code, lag, cfg_exp;
	logic [1:0] pups;
	logic [31:0] rom_data, seed;
	logic [23:0] rom_addr;
	logic [7:0] slv_addr, slv_data, host_addr, host_data, gpin, g_out, g_oe, g_pu, g_pd;
	logic [7:0] dir, lvl, sel, en, g_in;
	logic [3:0] stage;
	logic [5:0] chg_en;
	logic [15:0] seen;
	int bad_count, checks;

	hbs_boot_sequencer u_hbs_boot_sequencer (.mclk_in(mclk), .rst_n_in(rst_n),
		.chg_pull_up_in(chg[0]), .chg_strong_in(chg[1]), .chg_very_strong_in(chg[2]),
		.cfg_pull_up_in(cfg[0]), .cfg_strong_in(cfg[1]), .cfg_very_strong_in(cfg[2]),
		.spi_strap_in(spi), .mgmt_data_pin_pu_in(pups[0]), .mgmt_clock_pin_pu_in(pups[1]),
		.pll_locked_in(lock), .rom_done_in(rom_done), .rom_data_in(rom_data),
		.rom_dual_in(dual), .rom_mode3_in(mode3), .slv_wr_in(slv_wr), .slv_addr_in(slv_addr),
		.slv_data_in(slv_data), .host_wr_in(host_wr), .host_addr_in(host_addr),
		.host_data_in(host_data), .otp_override_in(1'b0), .vbus_in(vbus), .gpio_pin_in(gpin),
		.stage_out(stage), .pll_run_out(pll_run), .port_oe_out(port_oe), .rom_rd_out(rom_rd),
		.rom_addr_out(rom_addr), .rom_dual_out(dual_o), .rom_mode3_out(mode3_o),
		.exec_external_out(ext), .mgmt_slave_out(slave), .charge_en_out(chg_en),
		.slave_config_setting_out(cfg_code), .config_locked_out(locked),
		.charger_detect_stage_out(chg_det), .hub_connect_out(hub_con), .gpio_out(g_out),
		.gpio_oe_out(g_oe), .gpio_pu_en_out(g_pu), .gpio_pd_en_out(g_pd), .gpio_in_q_out(g_in));
	hbs_far_model u_hbs_far_model (.mclk_in(mclk), .rom_rd_in(rom_rd), .rom_addr_in(rom_addr),
		.sig_ok_in(sig_ok), .lag_in(lag), .rom_done_out(rom_done), .rom_data_out(rom_data),
		.slv_wr_out(slv_wr), .slv_addr_out(slv_addr), .slv_data_out(slv_data));

	// clock and a record of every stage visited
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// cleared while reset is low so each boot starts with a clean record
	always @(negedge mclk) seen <= rst_n ? (seen | (16'h0001 << stage)) : 16'h0000;

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// strap code to sense bits {10 ohm, 10k, pull-up}
	function automatic logic [2:0] sense(input logic [2:0] c);
		return {c[2:1] == 2'h2, c[2:1] == 2'h1, c[0]};
	endfunction
	function automatic logic [5:0] mask_of(input logic [2:0] c);
		case (c)
			3'h1: return 6'h01;
			3'h2: return 6'h03;
			3'h3: return 6'h07;
			3'h4: return 6'h0F;
			3'h5: return 6'h3F;
			default: return 6'h00;
		endcase
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wait_stage(input hbs_stage_t s);
		int n;
		n = 0;
		while (stage !== s && n < 600)
		begin
			@(negedge mclk);
			n++;
		end
		chk(stage, s);
	endtask
	task automatic host_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		host_wr = 1'b1;
		host_addr = a;
		host_data = d;
		@(negedge mclk);
		host_wr = 1'b0;
	endtask
	task automatic end_of_test();
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	initial
	begin
		#800000;
		bad_count++;
		end_of_test();
	end

	// six boots walk every charge strap code through spi, internal and soc paths
	initial
	begin
		seed = 32'h2B6A;
		{rst_n, spi, lock, dual, mode3, host_wr, vbus, sig_ok, chg, cfg, pups} = '0;
		{lag, host_addr, host_data, gpin} = '0;
		bad_count = 0;
		checks = 0;
		for (int i = 0; i < 6; i++)
		begin
			rst_n = 1'b0;
			{vbus, lock} = 2'h0;
			spi = (i < 3);
			sig_ok = i[0];
			chg = sense(3'(i));
			cfg_exp = (i > 2) ? HBS_STRAP_PU200K : 3'(rnd() % 6);
			cfg = sense(cfg_exp);
			pups = (i == 3) ? 2'h1 : 2'h3;
			{dual, mode3, lag, gpin} = 13'(rnd());
			repeat (6) @(negedge mclk);
			chk(stage, HBS_STANDBY);
			chk({port_oe, pll_run, hub_con, locked, g_oe}, 0);
			rst_n = 1'b1;
			repeat (3) @(negedge mclk);
			lock = 1'b1;
			if (spi)
			begin
				wait_stage(HBS_SPI_PROBE);
				chk({rom_rd, rom_addr}, {1'b1, HBS_SIG_ADDR});
				wait_stage(sig_ok ? HBS_SPI_EXEC : HBS_CFG_READ);
				chk({ext, rom_rd, rom_addr}, sig_ok ? {2'h2, HBS_EXEC_ADDR} : {2'h0, HBS_SIG_ADDR});
			end
			wait_stage(HBS_STRAP_CHECK);
			chk(seen[HBS_SPI_PROBE], spi);
			if (i > 3)
			begin
				wait_stage(HBS_SOC_CFG);
				chk(slave, 1'b1);
				u_hbs_far_model.soc_write(8'h00, 8'hFF);
				repeat (50 + rnd() % 250) @(negedge mclk);
				chk(stage, HBS_SOC_CFG);
				chk(g_oe, 8'h00);
				u_hbs_far_model.soc_write(HBS_SOC_DONE_REG, 8'(rnd()));
			end
			wait_stage(HBS_MERGE);
			wait_stage(HBS_SUSPEND);
			chk(seen[HBS_SOC_CFG], i > 3);
			chk({locked, pll_run, hub_con, g_oe}, {2'h3, 9'h000});
			chk({cfg_code, chg_en}, {cfg_exp, mask_of(3'(i))});
			chk(slave, cfg_exp == HBS_STRAP_PU200K);
			chk({dual_o, mode3_o}, {dual, mode3});
			{dir, lvl, sel, en} = rnd();
			// both parties write direction at once, the host must win
			fork
				host_write(8'h00, dir);
				u_hbs_far_model.soc_write(8'h00, ~dir);
			join
			if (i[0])
				host_write(8'h01, lvl);
			else
				u_hbs_far_model.soc_write(8'h01, lvl);
			host_write(8'h02, sel);
			u_hbs_far_model.soc_write(8'h03, en);
			repeat (2) @(negedge mclk);
			chk(g_oe, dir);
			chk(g_out, lvl);
			chk(g_in, gpin);
			chk({g_pu, g_pd}, {en & sel & ~dir, en & ~sel & ~dir});
			vbus = 1'b1;
			if (i != 0)
			begin
				wait_stage(HBS_CHARGER_DETECT);
				chk(chg_det, 1'b1);
			end
			wait_stage(HBS_CONNECT);
			chk(seen[HBS_CHARGER_DETECT], i != 0);
			repeat (rnd() % 40) @(negedge mclk);
			chk({stage, hub_con, port_oe, chg_det}, {HBS_CONNECT, 3'h6});
			vbus = 1'b0;
			wait_stage(HBS_IDLE);
			chk(hub_con, 1'b0);
		end
		end_of_test();
	end
endmodule
